//--- logic/wwd_control.sv
/*
 * Window watchdog control and status: window timing, fault reset pin,
 * fault counting with restart threshold, configuration freeze and the
 * restart flag with its self-clearing strobes.
 * Assumes a single 10 MHz clock, a synchronous active-high reset, a simple
 * internal register port at the printed offsets and a trigger input that is
 * already synchronous to the clock.
 */
// Notes on behaviour
// - closed window 10/20/50/100 ms from bits 7-6.
// - open window 20/100/200/600 ms from bits 5-4.
// - first window 200/600/2000/5000 ms from bits 3-2.
// - restart after 1/2/4 faults; code 0 disables.
// - freeze bit blocks config writes until reset.
// - status register writes ignore the freeze.
// - blocking mode: set flag stops further restarts.
// - reload defaults on restart only when enabled.
// - option bit 2 drives trigger pull-down enable.
// - option bit 1 selects fault output polarity.
// - option bit 0 selects open-drain; reset open-drain.
// - status bit 4 write makes one flag clear pulse.
// - restart sets flag; only clear strobe or reset clears it.
// - status bit 2 write pulses count clear.
// - status bits 1-0 show fault count.
`timescale 1ns/1ps

`include "wwd_defs.svh"

module wwd_control #(
	parameter int unsigned TICK_CYC = `WWD_TICK_CYC   // Clock cycles per millisecond tick.
) (
	// Clock and reset.
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	// Register port.
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic        i_reg_wr,
	input  wire logic [7:0]  i_reg_wdata,
	output logic      [7:0]  o_reg_rdata,
	// Host supervision pins.
	input  wire logic        i_trigger_input,
	output logic             o_trigger_pulldown_en,
	output logic             o_fault_reset_output,
	output logic             o_fault_reset_oe,
	// System restart requests.
	output logic             o_sys_restart,
	output logic             o_reload_defaults
);
	import wwd_pkg::*;

	wwd_state_s state_reg;   // Registered state of the whole block.
	wwd_state_s state_next;  // Next value of the state.

	// Closed window length in ticks.
	function automatic logic [12:0] closed_ms(input logic [1:0] sel);
		case (sel)
			2'h0:    closed_ms = 13'h000A;
			2'h1:    closed_ms = 13'h0014;
			2'h2:    closed_ms = 13'h0032;
			default: closed_ms = 13'h0064;
		endcase
	endfunction

	// Open window length in ticks.
	function automatic logic [12:0] open_ms(input logic [1:0] sel);
		case (sel)
			2'h0:    open_ms = 13'h0014;
			2'h1:    open_ms = 13'h0064;
			2'h2:    open_ms = 13'h00C8;
			default: open_ms = 13'h0258;
		endcase
	endfunction

	// First (long) open window length in ticks.
	function automatic logic [12:0] first_ms(input logic [1:0] sel);
		case (sel)
			2'h0:    first_ms = 13'h00C8;
			2'h1:    first_ms = 13'h0258;
			2'h2:    first_ms = 13'h07D0;
			default: first_ms = 13'h1388;
		endcase
	endfunction

	// Number of faults that starts a restart; zero means never.
	function automatic logic [2:0] threshold(input logic [1:0] sel);
		case (sel)
			2'h0:    threshold = 3'h0;
			2'h1:    threshold = 3'h1;
			2'h2:    threshold = 3'h2;
			default: threshold = 3'h4;
		endcase
	endfunction

	// Next-state logic for the whole block.
	always_comb begin
		logic        wr_window;    // Write to the window configuration.
		logic        wr_option;    // Write to the option configuration.
		logic        wr_status;    // Write to the status register.
		logic        tick;         // One millisecond has elapsed.
		logic        trig_edge;    // Rising edge on the trigger input.
		logic        fault_event;  // A window violation happened now.
		logic        pulse_done;   // The fault pulse has just finished.
		logic [12:0] limit;        // Length of the current phase.
		logic [2:0]  count_inc;    // Fault count after this fault.
		logic [2:0]  thr;          // Selected restart threshold.
		logic        restart_go;   // A restart starts this cycle.
		logic        asserted;     // Fault reset logically active.
		logic        level;        // Fault pin level before drain mode.

		state_next  = state_reg;
		wr_window   = i_reg_wr && (i_reg_addr == `WWD_ADDR_WINDOW_CFG);
		wr_option   = i_reg_wr && (i_reg_addr == `WWD_ADDR_OPTION_CFG);
		wr_status   = i_reg_wr && (i_reg_addr == `WWD_ADDR_STATUS);
		tick        = (state_reg.prescale == 24'(TICK_CYC - 1));
		trig_edge   = i_trigger_input && !state_reg.trigger_prev;
		fault_event = 1'b0;
		pulse_done  = 1'b0;
		limit       = 13'h0000;
		count_inc   = {1'b0, state_reg.fault_count} + 3'h1;
		thr         = threshold(state_reg.window_cfg[`WWD_THRESH_SEL_HI:`WWD_THRESH_SEL_LO]);
		restart_go  = 1'b0;

		// Tick prescaler runs freely, so a closed window started by a trigger can be up to one tick short.
		state_next.prescale     = tick ? 24'h000000 : state_reg.prescale + 24'h000001;
		state_next.trigger_prev = i_trigger_input;

		// Configuration writes are dropped once the freeze bit is set.
		if (!state_reg.option_cfg[`WWD_FREEZE_BIT]) begin
			if (wr_window) begin
				state_next.window_cfg = i_reg_wdata;
			end
			if (wr_option) begin
				state_next.option_cfg = i_reg_wdata;
			end
		end

		// Status writes ignore the freeze; only strobes and spare bits store.
		state_next.flag_clear  = 1'b0;
		state_next.count_clear = 1'b0;
		if (wr_status) begin
			state_next.status_spare = i_reg_wdata[7:5];
			state_next.flag_clear   = i_reg_wdata[`WWD_FLAG_CLEAR_BIT];
			state_next.count_clear  = i_reg_wdata[`WWD_COUNT_CLEAR_BIT];
		end

		// A pending clear pulse acts now; a new event below overrides it.
		if (state_reg.flag_clear) begin
			state_next.restart_flag = 1'b0;
		end
		if (state_reg.count_clear) begin
			state_next.fault_count = 2'h0;
			count_inc              = 3'h1;
		end

		// Window sequencing in millisecond ticks.
		case (state_reg.phase)
			WWD_FIRST: begin
				limit = first_ms(state_reg.window_cfg[`WWD_FIRST_SEL_HI:`WWD_FIRST_SEL_LO]);
			end
			WWD_CLOSED: begin
				limit = closed_ms(state_reg.window_cfg[`WWD_CLOSED_SEL_HI:`WWD_CLOSED_SEL_LO]);
			end
			WWD_OPEN: begin
				limit = open_ms(state_reg.window_cfg[`WWD_OPEN_SEL_HI:`WWD_OPEN_SEL_LO]);
			end
			WWD_FAULT: begin
				limit = `WWD_FAULT_PULSE_MS;
			end
			default: begin
				limit = 13'h0001;
			end
		endcase

		if (tick) begin
			state_next.ms_count = state_reg.ms_count + 13'h0001;
		end

		case (state_reg.phase)
			WWD_FIRST, WWD_OPEN: begin
				// A trigger in an open window starts the next closed window.
				if (trig_edge) begin
					state_next.phase    = WWD_CLOSED;
					state_next.ms_count = 13'h0000;
				end else if (tick && (state_reg.ms_count + 13'h0001 >= limit)) begin
					fault_event = 1'b1;
				end
			end
			WWD_CLOSED: begin
				// A trigger during the closed window is an early trigger.
				if (trig_edge) begin
					fault_event = 1'b1;
				end else if (tick && (state_reg.ms_count + 13'h0001 >= limit)) begin
					state_next.phase    = WWD_OPEN;
					state_next.ms_count = 13'h0000;
				end
			end
			WWD_FAULT: begin
				// Triggers are ignored while the fault pulse is out.
				if (tick && (state_reg.ms_count + 13'h0001 >= limit)) begin
					pulse_done          = 1'b1;
					state_next.phase    = WWD_FIRST;
					state_next.ms_count = 13'h0000;
				end
			end
			default: begin
				state_next.phase    = WWD_FIRST;
				state_next.ms_count = 13'h0000;
			end
		endcase

		if (fault_event) begin
			state_next.phase    = WWD_FAULT;
			state_next.ms_count = 13'h0000;
		end

		// Each fault pulse is counted once, at its start.
		state_next.sys_restart = 1'b0;
		state_next.reload      = 1'b0;
		if (fault_event) begin
			if ((thr != 3'h0) && (count_inc >= thr)) begin
				// Blocking mode holds off restarts while the flag is set.
				restart_go = !(state_reg.option_cfg[`WWD_BLOCKING_BIT]
					&& state_reg.restart_flag);
			end
			if (restart_go) begin
				state_next.fault_count  = 2'h0;
				state_next.restart_flag = 1'b1;
				state_next.sys_restart  = 1'b1;
				state_next.reload       = state_reg.option_cfg[`WWD_RELOAD_BIT];
			end else begin
				// Saturate so that a blocked count does not wrap to zero.
				state_next.fault_count = count_inc[2] ? 2'h3 : count_inc[1:0];
			end
		end

		// Fault pin: polarity then drive type, both taken live.
		asserted = (state_next.phase == WWD_FAULT) && !pulse_done;
		level    = asserted ^ state_reg.option_cfg[`WWD_POLARITY_BIT];
		if (state_reg.option_cfg[`WWD_DRAIN_BIT]) begin
			state_next.fault_out = 1'b0;
			state_next.fault_oe  = !level;
		end else begin
			state_next.fault_out = level;
			state_next.fault_oe  = 1'b1;
		end

		// Read data follows the address one cycle later.
		case (i_reg_addr)
			`WWD_ADDR_WINDOW_CFG: begin
				state_next.rdata = state_reg.window_cfg;
			end
			`WWD_ADDR_OPTION_CFG: begin
				state_next.rdata = state_reg.option_cfg;
			end
			`WWD_ADDR_STATUS: begin
				state_next.rdata = {state_reg.status_spare, state_reg.flag_clear,
					state_reg.restart_flag, state_reg.count_clear,
					state_reg.fault_count};
			end
			default: begin
				state_next.rdata = 8'h00;
			end
		endcase
	end

	// State register; reset puts the block at the start of the first window.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_reg              <= '0;
			state_reg.window_cfg   <= `WWD_RST_WINDOW_CFG;
			state_reg.option_cfg   <= `WWD_RST_OPTION_CFG;
			state_reg.phase        <= WWD_FIRST;
			state_reg.fault_oe     <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs come straight from the state record.
	assign o_reg_rdata           = state_reg.rdata;
	assign o_trigger_pulldown_en = state_reg.option_cfg[`WWD_PULLDOWN_BIT];
	assign o_fault_reset_output  = state_reg.fault_out;
	assign o_fault_reset_oe      = state_reg.fault_oe;
	assign o_sys_restart         = state_reg.sys_restart;
	assign o_reload_defaults     = state_reg.reload;

endmodule

//--- pkg/wwd_defs.svh
/*
 * Constants of the window watchdog control block: register offsets, field
 * positions, reset values and timing figures.
 * Assumes it is included by files that need these names, and nothing else.
 */
`ifndef WWD_DEFS_SVH
`define WWD_DEFS_SVH

// Register offsets on the internal register port.
`define WWD_ADDR_WINDOW_CFG  8'h1C
`define WWD_ADDR_OPTION_CFG  8'h1D
`define WWD_ADDR_STATUS      8'h1E

// Reset values of the three registers.
`define WWD_RST_WINDOW_CFG   8'h00
`define WWD_RST_OPTION_CFG   8'h01
`define WWD_RST_STATUS       8'h00

// Field positions in the window configuration register.
`define WWD_CLOSED_SEL_HI    7
`define WWD_CLOSED_SEL_LO    6
`define WWD_OPEN_SEL_HI      5
`define WWD_OPEN_SEL_LO      4
`define WWD_FIRST_SEL_HI     3
`define WWD_FIRST_SEL_LO     2
`define WWD_THRESH_SEL_HI    1
`define WWD_THRESH_SEL_LO    0

// Field positions in the option configuration register.
`define WWD_FREEZE_BIT       7
`define WWD_BLOCKING_BIT     4
`define WWD_RELOAD_BIT       3
`define WWD_PULLDOWN_BIT     2
`define WWD_POLARITY_BIT     1
`define WWD_DRAIN_BIT        0

// Field positions in the status register.
`define WWD_FLAG_CLEAR_BIT   4
`define WWD_FLAG_BIT         3
`define WWD_COUNT_CLEAR_BIT  2

// Timing: one millisecond tick at a 100 ns clock period.
`define WWD_CLK_PERIOD_NS    100
`define WWD_TICK_TIME_NS     1000000
`define WWD_TICK_CYC         (`WWD_TICK_TIME_NS / `WWD_CLK_PERIOD_NS)
`define WWD_FAULT_PULSE_MS   13'h0002

`endif

//--- pkg/wwd_pkg.sv
/*
 * Types of the window watchdog control block: the supervision states and the
 * packed state record of the control module.
 * Assumes the constants header is compiled alongside it.
 */
package wwd_pkg;

	// Supervision phases of the watchdog.
	typedef enum logic [1:0] {
		WWD_FIRST,
		WWD_CLOSED,
		WWD_OPEN,
		WWD_FAULT
	} wwd_phase_e;

	// Complete state of the control module, registered as one record.
	typedef struct packed {
		logic [7:0]  window_cfg;      // Window configuration register.
		logic [7:0]  option_cfg;      // Option configuration register.
		logic [2:0]  status_spare;    // Spare writable status bits 7-5.
		logic        flag_clear;      // Restart-flag clear pulse.
		logic        restart_flag;    // Watchdog restart has occurred.
		logic        count_clear;     // Fault-count clear pulse.
		logic [1:0]  fault_count;     // Issued fault resets, saturating.
		wwd_phase_e  phase;           // Current supervision phase.
		logic [23:0] prescale;        // Cycles within the current tick.
		logic [12:0] ms_count;        // Ticks spent in the current phase.
		logic        trigger_prev;    // Trigger level one cycle ago.
		logic        fault_out;       // Fault pin level.
		logic        fault_oe;        // Fault pin output enable.
		logic        sys_restart;     // Restart request pulse.
		logic        reload;          // Defaults reload pulse.
		logic [7:0]  rdata;           // Read data held for the port.
	} wwd_state_s;

endpackage

//--- test/wwd_host_model.sv
/*
 * Host processor model: services the watchdog trigger and watches the fault pin.
 * Assumes the bench sets the service delay, enable and expected polarity.
 */
`timescale 1ns/1ps
module wwd_host_model (
	// Clock.
	input  wire logic        i_clock,
	// Bench control.
	input  wire logic        i_enable,
	input  wire logic [11:0] i_delay,
	input  wire logic        i_pol,
	// Watchdog pins.
	input  wire logic        i_fault_out,
	input  wire logic        i_fault_oe,
	output logic             o_trigger,
	output logic             o_active
);
	logic [11:0] count_reg = 12'h000;  // Cycles since the last trigger or fault end.
	logic        pin;                  // Resolved pin level.
	// A released pin is pulled high on the board.
	assign pin = i_fault_oe ? i_fault_out : 1'b1;
	assign o_active = pin ^ i_pol;
	// The count stays at zero while the fault is shown, so service resumes after it ends.
	always @(posedge i_clock) begin
		o_trigger <= 1'b0;
		if (o_active || !i_enable) begin
			count_reg <= 12'h000;
		end else if (count_reg >= i_delay) begin
			o_trigger <= 1'b1;
			count_reg <= 12'h000;
		end else begin
			count_reg <= count_reg + 12'h001;
		end
	end
endmodule

//--- test/wwd_control_properties.sv
/*
 * Port checker of the window watchdog control block.
 * Assumes it is bound to the block and that a tick is four clock cycles.
 */
`timescale 1ns/1ps
module wwd_control_properties #(
	parameter int unsigned TICK_CYC = 4
) (
	input wire logic       i_clock,
	input wire logic       i_rst,
	input wire logic [7:0] i_reg_addr,
	input wire logic       i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	input wire logic       i_trigger_input,
	input wire logic       o_trigger_pulldown_en,
	input wire logic       o_fault_reset_output,
	input wire logic       o_fault_reset_oe,
	input wire logic       o_sys_restart,
	input wire logic       o_reload_defaults
);
	logic [7:0] opt_reg;     // Option register as written through the port.
	logic       frozen_reg;  // Freeze seen on the port.
	logic       act;         // Fault shown on the pin.
	assign act = (o_fault_reset_oe ? o_fault_reset_output : 1'b1) ^ opt_reg[1];
	// The shadow refuses writes once frozen, just as the block must.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			opt_reg <= 8'h01;
			frozen_reg <= 1'b0;
		end else if (i_reg_wr && i_reg_addr == 8'h1D && !frozen_reg) begin
			opt_reg <= i_reg_wdata;
			frozen_reg <= i_reg_wdata[7];
		end
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	restart_pulse_a: assert property (o_sys_restart |=> !o_sys_restart)
		else $error("restart pulse longer than one cycle");
	restart_fault_a: assert property (o_sys_restart && !opt_reg[0] |-> $rose(act))
		else $error("restart without a fault start");
	reload_pair_a: assert property (o_sys_restart || o_reload_defaults |->
		o_sys_restart && (o_reload_defaults == opt_reg[3]))
		else $error("reload pulse does not match enable");
	freeze_hold_a: assert property ((frozen_reg && $stable(i_reg_addr) &&
		(i_reg_addr == 8'h1C || i_reg_addr == 8'h1D))[*3] |-> $stable(o_reg_rdata))
		else $error("frozen configuration changed");
	count_clear_a: assert property ((i_reg_wr && i_reg_addr == 8'h1E && i_reg_wdata[2]) ##1
		(!i_reg_wr && i_reg_addr == 8'h1E)[*2] |-> o_reg_rdata[2] ##1 !o_reg_rdata[2])
		else $error("count clear strobe wrong");
	flag_clear_a: assert property ((i_reg_wr && i_reg_addr == 8'h1E && i_reg_wdata[4]) ##1
		(!i_reg_wr && i_reg_addr == 8'h1E)[*2] |-> o_reg_rdata[4] ##1 o_reg_rdata[4:3] == 2'b00)
		else $error("flag clear strobe wrong");
	pulldown_follow_a: assert property ($stable(opt_reg) |-> o_trigger_pulldown_en == opt_reg[2])
		else $error("pull-down enable wrong");
	drive_enable_a: assert property ($stable(opt_reg) && !opt_reg[0] |-> o_fault_reset_oe)
		else $error("push-pull pin not driven");
	fault_width_a: assert property ($rose(act) && !opt_reg[0] && $stable(opt_reg) |->
		act[*5] ##[1:4] !act)
		else $error("fault pulse width wrong");
	cover property (o_sys_restart);
	cover property (o_reload_defaults);
	cover property ($rose(act) && !opt_reg[0]);
endmodule

bind wwd_control wwd_control_properties #(.TICK_CYC(TICK_CYC)) u_props (
	.i_clock(i_clock), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
	.i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_trigger_input(i_trigger_input),
	.o_trigger_pulldown_en(o_trigger_pulldown_en), .o_fault_reset_output(o_fault_reset_output),
	.o_fault_reset_oe(o_fault_reset_oe), .o_sys_restart(o_sys_restart),
	.o_reload_defaults(o_reload_defaults));

//--- test/wwd_control_tb.sv
/*
 * Self-checking bench of the window watchdog control block.
 * Assumes a tick of four cycles and the host model on the trigger pin.
 */
`timescale 1ns/1ps
module wwd_control_tb;
	import wwd_pkg::*;
	logic       i_clock = 1'b0;
	logic       i_rst = 1'b1;
	logic       i_reg_wr = 1'b0;
	logic [7:0] i_reg_addr = 8'h00;
	logic [7:0] i_reg_wdata = 8'h00;
	logic [7:0] o_reg_rdata, rv;
	logic       i_trigger_input, o_trigger_pulldown_en, o_fault_reset_output;
	logic       o_fault_reset_oe, o_sys_restart, o_reload_defaults, act;
	logic       host_en = 1'b0;
	logic       pol = 1'b0;
	logic [11:0] host_dly = 12'd60;
	int errors = 0, tests_run = 0, restarts = 0, reloads = 0, cyc = 0, t0, r0, l0;
	int exp_r[4] = '{0, 4, 2, 1};
	logic [7:0] exp_s[4] = '{8'h03, 8'h08, 8'h08, 8'h08};
	always #50 i_clock = ~i_clock;
	// Count restart and reload pulses as they stand for one cycle.
	always @(posedge i_clock) begin
		cyc++;
		if (o_sys_restart === 1'b1) restarts++;
		if (o_reload_defaults === 1'b1) reloads++;
	end
	wwd_control #(.TICK_CYC(4)) dut (.i_clock(i_clock), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
		.i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
		.i_trigger_input(i_trigger_input), .o_trigger_pulldown_en(o_trigger_pulldown_en),
		.o_fault_reset_output(o_fault_reset_output), .o_fault_reset_oe(o_fault_reset_oe),
		.o_sys_restart(o_sys_restart), .o_reload_defaults(o_reload_defaults));
	wwd_host_model host (.i_clock(i_clock), .i_enable(host_en), .i_delay(host_dly), .i_pol(pol),
		.i_fault_out(o_fault_reset_output), .i_fault_oe(o_fault_reset_oe),
		.o_trigger(i_trigger_input), .o_active(act));
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// One write strobe; the next call waits a fresh edge before raising it again.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clock);
		i_reg_wr <= 1'b0;
	endtask
	// The extra edge lets clear strobes of a preceding write die away.
	task automatic rd(input logic [7:0] a);
		@(posedge i_clock);
		i_reg_addr <= a;
		repeat (2) @(posedge i_clock);
		#1 rv = o_reg_rdata;
	endtask
	task automatic wait_lvl(input logic v, input int lim);
		int n;
		n = 0;
		while (act !== v && n < lim) begin
			@(posedge i_clock);
			#1 n++;
		end
		if (act !== v) begin
			errors++;
			$display("Error at %0t: fault pin wait ran out", $time);
			end_sim();
		end
	endtask
	// Early triggers land in the closed window and each one makes a fault.
	task automatic faults(input int n);
		host_dly <= 12'd10;
		repeat (n) begin
			wait_lvl(1'b1, 3000);
			wait_lvl(1'b0, 100);
		end
		host_dly <= 12'd60;
	endtask
	initial begin
		repeat (4) @(posedge i_clock);
		i_rst <= 1'b0;
		t0 = cyc;
		rd(8'h1C); chk(rv, 8'h00);
		rd(8'h1D); chk(rv, 8'h01);
		rd(8'h1E); chk(rv, 8'h00);
		rd(8'h1F); chk(rv, 8'h00);
		wait_lvl(1'b1, 1200);
		chk(8'((cyc - t0 >= 794 && cyc - t0 <= 803)), 8'h01);
		wait_lvl(1'b0, 100);
		rd(8'h1E); chk(rv, 8'h01);
		wr(8'h1D, 8'h02); pol <= 1'b1; repeat (3) @(posedge i_clock);
		chk({7'h00, o_fault_reset_output}, 8'h01);
		wr(8'h1D, 8'h04); pol <= 1'b0; repeat (3) @(posedge i_clock);
		chk({7'h00, o_fault_reset_output}, 8'h00);
		chk({7'h00, o_trigger_pulldown_en}, 8'h01);
		wr(8'h1D, 8'h08); host_en <= 1'b1;
		repeat (1500) @(posedge i_clock);
		rd(8'h1E); chk(rv, 8'h01);
		for (int c = 0; c < 4; c++) begin
			wr(8'h1E, 8'h14); wr(8'h1C, c[7:0]);
			r0 = restarts; l0 = reloads;
			faults(4);
			chk(8'(restarts - r0), 8'(exp_r[c]));
			chk(8'(reloads - l0), 8'(exp_r[c]));
			rd(8'h1E); chk(rv, exp_s[c]);
		end
		wr(8'h1D, 8'h18); wr(8'h1C, 8'h01); r0 = restarts;
		faults(2);
		chk(8'(restarts - r0), 8'h00);
		rd(8'h1E); chk(rv, 8'h0A);
		wr(8'h1E, 8'h10); rd(8'h1E); chk(rv, 8'h02);
		wr(8'h1E, 8'h04); rd(8'h1E); chk(rv, 8'h00);
		wr(8'h1D, 8'h9C); wr(8'h1C, 8'hFF); wr(8'h1D, 8'h00);
		rd(8'h1C); chk(rv, 8'h01);
		rd(8'h1D); chk(rv, 8'h9C);
		faults(1);
		wr(8'h1E, 8'hF0); rd(8'h1E); chk(rv, 8'hE0);
		i_rst <= 1'b1; repeat (4) @(posedge i_clock); i_rst <= 1'b0;
		rd(8'h1D); chk(rv, 8'h01);
		end_sim();
	end
endmodule
